// ---- verilog/port_pin_state_pin_mux_upper.sv ----
// Port 1 general-purpose port with pin-function multiplexing of pins 7 to 4
`timescale 1ns/1ps

// Summary of operation
// RULE1: Output data register, 8 bits read/write, drives each general-output pin.
// RULE2: Output data register clears on power-on reset and in hardware standby.
// RULE3: Output data register holds its value through manual reset and software standby.
// RULE4: Pin-state register is read-only; writes to it do nothing.
// RULE5: Pin-state bits with direction 1 read the output data register bit.
// RULE6: Pin-state bits with direction 0 read the sampled pin level.
// RULE7: After power-on reset or hardware standby, pin-state shows real pin levels.
// RULE8: In manual reset and software standby the pin-state register holds.
// RULE9: Pin 7 drives channel 2 B compare output when selected, else general I/O.
// RULE10: Compare output when mode 0000 or 01xx and io control 1-3 or 5-7.
// RULE11: Mode 0011 gives PWM 2 output unless io xx00 or counter clears own register.
// RULE12: Mode 0010 gives channel 2 A PWM 1 output; channel 2 B output disabled.
// RULE13: Pin 7 feeds channel 2 B capture in normal modes when io bit 3 set.
// RULE14: Pin 6 feeds channel 2 A capture in normal modes when io bit 3 set.
// RULE15: Pin 5 feeds channel 1 B capture in normal modes when io is 10xx.
// RULE16: Pin 7 is external clock D when channel 0 or 5 prescaler is 111.
// RULE17: Pin 5 is external clock C for prescaler 110 on ch0/2 or 101 on ch4/5.
// RULE18: Pin 7 also feeds clock D phase input in phase counting on channels 2, 4.
// RULE19: Pin 5 also feeds clock C phase input in phase counting on channels 2, 4.
// RULE20: Pin 6 always routes its level to external interrupt 1.
// RULE21: Software should give an interrupt pin no other function.
// RULE22: Pin 4 muxes channel 1 A compare, general I/O, capture and interrupt 0.
// RULE23: Direction bit 1 makes the pin a general output, 0 a general input.
// RULE24: Direction register is write-only, clears on power-on and hardware standby.
// RULE25: Pin levels to timer and interrupt inputs pass a two-stage synchroniser.
module port_pin_state_pin_mux_upper
  import port_pin_state_pkg::*;
#(
  parameter int PIN_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic manual_reset,
  input wire logic sw_standby,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe,
  input wire logic [3:0] ch1_timer_mode_field,
  input wire logic [3:0] ch1_io_control_a,
  input wire logic [3:0] ch1_io_control_b,
  input wire logic [1:0] ch1_counter_clear_select,
  input wire logic [3:0] ch2_timer_mode_field,
  input wire logic [3:0] ch2_io_control_a,
  input wire logic [3:0] ch2_io_control_b,
  input wire logic [1:0] ch2_counter_clear_select,
  input wire logic [2:0] ch0_prescaler_select,
  input wire logic [2:0] ch2_prescaler_select,
  input wire logic [2:0] ch4_prescaler_select,
  input wire logic [2:0] ch5_prescaler_select,
  input wire logic ch2_phase_counting,
  input wire logic ch4_phase_counting,
  input wire logic ch1_compare_a,
  input wire logic ch1_compare_b,
  input wire logic ch2_compare_a,
  input wire logic ch2_compare_b,
  output logic ch1_capture_a,
  output logic ch1_capture_b,
  output logic ch2_capture_a,
  output logic ch2_capture_b,
  output logic ext_clock_c,
  output logic ext_clock_d,
  output logic ext_interrupt_0,
  output logic ext_interrupt_1
);

  // Mode 0000 or 01xx: normal and buffer-style modes where compare and capture apply
  function automatic logic mode_normal(input logic [3:0] mode);
    mode_normal = (mode == MODE_NORMAL) || (mode[3:2] == MODE_BUF_HI);
  endfunction

  // Io control 0001..0011 or 0101..0111 selects a compare output
  function automatic logic io_compare(input logic [3:0] io);
    io_compare = !io[3] && (io[1:0] != IO_NO_OUTPUT);
  endfunction

  // Output-compare or PWM 2 output of one compare pin
  function automatic logic cmp_out_sel(input logic [3:0] mode, input logic [3:0] io,
                                       input logic [1:0] cclr, input logic [1:0] own_clear);
    cmp_out_sel = (mode_normal(mode) && io_compare(io)) ||
                  ((mode == MODE_PWM2) && (io[1:0] != IO_NO_OUTPUT) && (cclr != own_clear));
  endfunction

  logic [7:0] port_output_data_ff;
  logic [7:0] port_direction_ff;
  logic [7:0] port_pin_state_ff;
  logic [7:0] nxt_pin_state;
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  logic [PIN_W-1:0] pin_out_ff;
  logic [PIN_W-1:0] pin_oe_ff;
  logic [PIN_W-1:0] nxt_pin_out;
  logic [PIN_W-1:0] nxt_pin_oe;
  logic wait_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic holding;
  logic wr_take;
  logic rd_take;
  logic sel_ch2b_out;
  logic sel_ch2a_out;
  logic sel_ch1b_out;
  logic sel_ch1a_out;
  logic ch1_capture_a_ff;
  logic ch1_capture_b_ff;
  logic ch2_capture_a_ff;
  logic ch2_capture_b_ff;
  logic ext_clock_c_ff;
  logic ext_clock_d_ff;
  logic ext_interrupt_0_ff;
  logic ext_interrupt_1_ff;

  // Manual reset and software standby freeze software-visible state
  assign holding = manual_reset || sw_standby;

  // Avalon slave: one wait cycle, then the access completes with waitrequest low
  assign rd_take = avs_read && wait_ff;
  assign wr_take = avs_write && !wait_ff && avs_byteenable[LANE_LOW] && !holding;

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else if ((avs_read || avs_write) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_readdata = READ_ZERO;
    case (avs_address)
      OFS_OUTPUT_DATA: begin
        nxt_readdata = {24'h00_0000, port_output_data_ff};
      end
      OFS_PIN_STATE: begin
        nxt_readdata = {24'h00_0000, port_pin_state_ff};
      end
      // Direction is write-only; it reads as zero, as do unmapped words
      default: begin
        nxt_readdata = READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_ff <= READ_ZERO;
    end else if (rd_take) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // Output data register
  always_ff @(posedge clk) begin
    if (rst || hw_standby) begin
      port_output_data_ff <= RST_OUTPUT_DATA; // RULE2
    end else if (wr_take && (avs_address == OFS_OUTPUT_DATA)) begin
      port_output_data_ff <= avs_writedata[7:0]; // RULE1
    end
    // Writes are blocked while holding, so contents survive // RULE3
  end

  // Direction register
  always_ff @(posedge clk) begin
    if (rst || hw_standby) begin
      port_direction_ff <= RST_DIRECTION; // RULE24
    end else if (wr_take && (avs_address == OFS_DIRECTION)) begin
      port_direction_ff <= avs_writedata[7:0]; // RULE24
    end
  end

  // Pin synchroniser; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in; // RULE25
      pin_sync_ff <= pin_meta_ff; // RULE25
    end
  end

  // Pin-state register: a write to its offset is decoded nowhere // RULE4
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port_direction_ff[i]) begin
        nxt_pin_state[i] = port_output_data_ff[i]; // RULE5
      end else begin
        nxt_pin_state[i] = pin_sync_ff[i]; // RULE6
      end
    end
  end

  // Pin-state clears on power-on and loads pin levels in hardware standby, so tracking resumes on pin levels
  always_ff @(posedge clk) begin
    if (rst) begin
      port_pin_state_ff <= '0;
    end else if (hw_standby) begin
      port_pin_state_ff <= pin_sync_ff[7:0]; // RULE7
    end else if (!holding) begin
      port_pin_state_ff <= nxt_pin_state; // RULE6
    end
    // While holding the last value is kept // RULE8
  end

  // Compare output selection per shared pin
  always_comb begin
    sel_ch2b_out = cmp_out_sel(ch2_timer_mode_field, ch2_io_control_b,
                               ch2_counter_clear_select, CCLR_ON_B); // RULE10 RULE11
    // Mode 0010 never enables channel 2 B: the function covers no PWM 1 case for B // RULE12
    sel_ch2a_out = cmp_out_sel(ch2_timer_mode_field, ch2_io_control_a,
                               ch2_counter_clear_select, CCLR_ON_A) || // RULE11
                   ((ch2_timer_mode_field == MODE_PWM1) &&
                    (ch2_io_control_a[1:0] != IO_NO_OUTPUT)); // RULE12
    sel_ch1b_out = cmp_out_sel(ch1_timer_mode_field, ch1_io_control_b,
                               ch1_counter_clear_select, CCLR_ON_B); // RULE11
    sel_ch1a_out = cmp_out_sel(ch1_timer_mode_field, ch1_io_control_a,
                               ch1_counter_clear_select, CCLR_ON_A) ||
                   ((ch1_timer_mode_field == MODE_PWM1) &&
                    (ch1_io_control_a[1:0] != IO_NO_OUTPUT)); // RULE22
  end

  // Pin drivers: general port first, timer outputs override on the upper pins
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      nxt_pin_oe[i] = (i < 8) ? port_direction_ff[i % 8] : 1'b0; // RULE23
      nxt_pin_out[i] = (i < 8) ? port_output_data_ff[i % 8] : 1'b0; // RULE1
    end
    if (hw_standby) begin
      nxt_pin_oe = '0;
      nxt_pin_out = '0;
    end else begin
      if (sel_ch2b_out) begin
        nxt_pin_oe[PIN_CH2_B] = 1'b1; // RULE9
        nxt_pin_out[PIN_CH2_B] = ch2_compare_b; // RULE9
      end
      if (sel_ch2a_out) begin
        nxt_pin_oe[PIN_CH2_A] = 1'b1;
        nxt_pin_out[PIN_CH2_A] = ch2_compare_a; // RULE12
      end
      if (sel_ch1b_out) begin
        nxt_pin_oe[PIN_CH1_B] = 1'b1;
        nxt_pin_out[PIN_CH1_B] = ch1_compare_b; // RULE10
      end
      if (sel_ch1a_out) begin
        nxt_pin_oe[PIN_CH1_A] = 1'b1;
        nxt_pin_out[PIN_CH1_A] = ch1_compare_a; // RULE22
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // Capture inputs to the timer, from synchronised pin levels; zero when not selected
  always_ff @(posedge clk) begin
    if (rst) begin
      ch2_capture_b_ff <= 1'b0;
      ch2_capture_a_ff <= 1'b0;
      ch1_capture_b_ff <= 1'b0;
      ch1_capture_a_ff <= 1'b0;
    end else begin
      ch2_capture_b_ff <= mode_normal(ch2_timer_mode_field) && ch2_io_control_b[3] &&
                          pin_sync_ff[PIN_CH2_B]; // RULE13
      ch2_capture_a_ff <= mode_normal(ch2_timer_mode_field) && ch2_io_control_a[3] &&
                          pin_sync_ff[PIN_CH2_A]; // RULE14
      ch1_capture_b_ff <= mode_normal(ch1_timer_mode_field) &&
                          (ch1_io_control_b[3:2] == IO_CAPTURE_CH1) &&
                          pin_sync_ff[PIN_CH1_B]; // RULE15
      ch1_capture_a_ff <= mode_normal(ch1_timer_mode_field) &&
                          (ch1_io_control_a[3:2] == IO_CAPTURE_CH1) &&
                          pin_sync_ff[PIN_CH1_A]; // RULE22
    end
  end

  // External clock inputs; a phase counting channel needs both clock pins
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_clock_d_ff <= 1'b0;
      ext_clock_c_ff <= 1'b0;
    end else begin
      ext_clock_d_ff <= ((ch0_prescaler_select == PSC_EXT_D) ||
                         (ch5_prescaler_select == PSC_EXT_D) || // RULE16
                         ch2_phase_counting || ch4_phase_counting) && // RULE18
                        pin_sync_ff[PIN_CH2_B];
      ext_clock_c_ff <= ((ch0_prescaler_select == PSC_EXT_C_LO) ||
                         (ch2_prescaler_select == PSC_EXT_C_LO) ||
                         (ch4_prescaler_select == PSC_EXT_C_HI) ||
                         (ch5_prescaler_select == PSC_EXT_C_HI) || // RULE17
                         ch2_phase_counting || ch4_phase_counting) && // RULE19
                        pin_sync_ff[PIN_CH1_B];
    end
  end

  // Interrupt pins pass their level through unconditionally; sharing is software's care
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_interrupt_1_ff <= 1'b0;
      ext_interrupt_0_ff <= 1'b0;
    end else begin
      ext_interrupt_1_ff <= pin_sync_ff[PIN_CH2_A]; // RULE20
      ext_interrupt_0_ff <= pin_sync_ff[PIN_CH1_A]; // RULE22
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = wait_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign ch1_capture_a = ch1_capture_a_ff;
  assign ch1_capture_b = ch1_capture_b_ff;
  assign ch2_capture_a = ch2_capture_a_ff;
  assign ch2_capture_b = ch2_capture_b_ff;
  assign ext_clock_c = ext_clock_c_ff;
  assign ext_clock_d = ext_clock_d_ff;
  assign ext_interrupt_0 = ext_interrupt_0_ff;
  assign ext_interrupt_1 = ext_interrupt_1_ff;

endmodule

// ---- verilog/port_pin_state_pkg.sv ----
// Register map, field codes and reset values of the port 1 block
package port_pin_state_pkg;

  // Avalon-MM word addressing: the slave address is a word index
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFS_OUTPUT_DATA = 2'h0;
  localparam logic [1:0] OFS_PIN_STATE = 2'h1;
  localparam logic [1:0] OFS_DIRECTION = 2'h2;

  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Byte lane that carries the 8-bit registers
  localparam int LANE_LOW = 0;

  // Timer mode field codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [1:0] MODE_BUF_HI = 2'h1;
  localparam logic [3:0] MODE_PWM1 = 4'h2;
  localparam logic [3:0] MODE_PWM2 = 4'h3;

  // Counter clear select codes that clear on the A or B register
  localparam logic [1:0] CCLR_ON_A = 2'h1;
  localparam logic [1:0] CCLR_ON_B = 2'h2;

  // Capture code of channel 1 io control (upper two bits); no-output code (lower two bits)
  localparam logic [1:0] IO_CAPTURE_CH1 = 2'h2;
  localparam logic [1:0] IO_NO_OUTPUT = 2'h0;

  // Prescaler codes that pick an external clock pin
  localparam logic [2:0] PSC_EXT_D = 3'h7;
  localparam logic [2:0] PSC_EXT_C_LO = 3'h6;
  localparam logic [2:0] PSC_EXT_C_HI = 3'h5;

  // Pin positions of the shared upper pins
  localparam int PIN_CH1_A = 4;
  localparam int PIN_CH1_B = 5;
  localparam int PIN_CH2_A = 6;
  localparam int PIN_CH2_B = 7;

  // Avalon answer latency in clock cycles after the request is seen
  localparam int BUS_LATENCY = 1;

endpackage

// ---- bench/port_pin_state_board_model.sv ----
// Board-side model of the eight port pins
`timescale 1ns/1ps
module port_pin_state_board_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] board,
  input wire logic [7:0] short_mask,
  output logic [7:0] pin_in
);
  // A shorted pin shows the board level even while the device drives it
  assign pin_in = (pin_oe & ~short_mask & pin_out) | (~(pin_oe & ~short_mask) & board);
endmodule

// ---- bench/port_pin_state_pin_mux_upper_properties.sv ----
// Assertion checker for the port 1 block
`timescale 1ns/1ps
module port_pin_state_checker
  import port_pin_state_pkg::*;
#(
  parameter int PIN_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [PIN_W-1:0] pin_in,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe,
  input wire logic [3:0] ch2_timer_mode_field,
  input wire logic [3:0] ch2_io_control_a,
  input wire logic [3:0] ch2_io_control_b,
  input wire logic [1:0] ch2_counter_clear_select,
  input wire logic ch2_compare_a,
  input wire logic ch2_compare_b,
  input wire logic ext_interrupt_1
);
  logic [2:0] age_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Synchroniser stages hold reset values for a few edges after release
  always_ff @(posedge clk) begin
    age_ff <= rst ? 3'h0 : (age_ff == 3'h4 ? age_ff : age_ff + 3'h1);
  end
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_one_cycle;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer held too long");
  property p_hi_zero;
    avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_dir_zero;
    avs_read && avs_waitrequest && avs_address == OFS_DIRECTION |=> avs_readdata == READ_ZERO;
  endproperty
  a_dir_zero: assert property (p_dir_zero) else $error("direction read not zero");
  property p_int1;
    age_ff == 3'h4 && pin_in[6] == $past(pin_in[6]) && pin_in[6] == $past(pin_in[6], 2)
      && pin_in[6] == $past(pin_in[6], 3) |-> ext_interrupt_1 == pin_in[6];
  endproperty
  a_int1: assert property (p_int1) else $error("interrupt 1 not following pin 6");
  // Read data must stand between reads, so a late-sampling master still sees it
  property p_rd_stands;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data changed without a read");
  property p_cmp_b;
    !hw_standby && (ch2_timer_mode_field == MODE_NORMAL || ch2_timer_mode_field[3:2] == MODE_BUF_HI)
      && ch2_io_control_b inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}
      |=> pin_oe[7] && pin_out[7] == $past(ch2_compare_b);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("pin 7 compare output wrong");
  property p_pwm2_a;
    !hw_standby && ch2_timer_mode_field == MODE_PWM2 && ch2_io_control_a[1:0] != IO_NO_OUTPUT
      && ch2_counter_clear_select != CCLR_ON_A |=> pin_oe[6] && pin_out[6] == $past(ch2_compare_a);
  endproperty
  a_pwm2_a: assert property (p_pwm2_a) else $error("pin 6 pwm output wrong");
  property p_hw_release;
    hw_standby [*3] |-> pin_oe == 8'h00;
  endproperty
  a_hw_release: assert property (p_hw_release) else $error("pins driven in standby");
endmodule

bind port_pin_state_pin_mux_upper port_pin_state_checker #(.PIN_W(PIN_W)) chk_u (.clk, .rst, .hw_standby, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .ch2_timer_mode_field,
  .ch2_io_control_a, .ch2_io_control_b, .ch2_counter_clear_select, .ch2_compare_a, .ch2_compare_b,
  .ext_interrupt_1);

// ---- bench/tb_port_pin_state_pin_mux_upper.sv ----
// Self-checking bench for the port 1 block
`timescale 1ns/1ps
module tb_port_pin_state_pin_mux_upper
  import port_pin_state_pkg::*;
;
  logic clk, rst, hw_standby, manual_reset, sw_standby, avs_read, avs_write, avs_waitrequest, cmp;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, ch1_timer_mode_field, ch1_io_control_a, ch1_io_control_b;
  logic [3:0] ch2_timer_mode_field, ch2_io_control_a, ch2_io_control_b;
  logic [1:0] ch1_counter_clear_select, ch2_counter_clear_select;
  logic [2:0] ch0_prescaler_select, ch2_prescaler_select, ch4_prescaler_select, ch5_prescaler_select;
  logic ch2_phase_counting, ch4_phase_counting, ch1_compare_a, ch1_compare_b, ch2_compare_a, ch2_compare_b;
  logic ch1_capture_a, ch1_capture_b, ch2_capture_a, ch2_capture_b, ext_clock_c, ext_clock_d;
  logic ext_interrupt_0, ext_interrupt_1;
  logic [7:0] pin_in, pin_out, pin_oe, board, short_mask, in_vec;
  logic [27:0] tmr;
  logic [13:0] psc;
  int mismatches, compares;

  assign {ch2_timer_mode_field, ch2_io_control_a, ch2_io_control_b, ch1_timer_mode_field, ch1_io_control_a,
    ch1_io_control_b, ch2_counter_clear_select, ch1_counter_clear_select} = tmr;
  assign {ch0_prescaler_select, ch2_prescaler_select, ch4_prescaler_select, ch5_prescaler_select,
    ch2_phase_counting, ch4_phase_counting} = psc;
  assign {ch1_compare_a, ch1_compare_b, ch2_compare_a, ch2_compare_b} = {4{cmp}};
  assign in_vec = {ch1_capture_a, ch1_capture_b, ch2_capture_a, ch2_capture_b, ext_clock_c, ext_clock_d,
    ext_interrupt_0, ext_interrupt_1};

  port_pin_state_pin_mux_upper dut_u (.clk, .rst, .hw_standby, .manual_reset, .sw_standby, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe,
    .ch1_timer_mode_field, .ch1_io_control_a, .ch1_io_control_b, .ch1_counter_clear_select,
    .ch2_timer_mode_field, .ch2_io_control_a, .ch2_io_control_b, .ch2_counter_clear_select,
    .ch0_prescaler_select, .ch2_prescaler_select, .ch4_prescaler_select, .ch5_prescaler_select,
    .ch2_phase_counting, .ch4_phase_counting, .ch1_compare_a, .ch1_compare_b, .ch2_compare_a, .ch2_compare_b,
    .ch1_capture_a, .ch1_capture_b, .ch2_capture_a, .ch2_capture_b, .ext_clock_c, .ext_clock_d,
    .ext_interrupt_0, .ext_interrupt_1);
  port_pin_state_board_model board_u (.pin_out, .pin_oe, .board, .short_mask, .pin_in);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) chk_reg(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk_reg(rd, exp);
  endtask

  // Two edges of pin synchronisation plus a register stage, and two edges spare
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  task automatic t_regs();
    bus(1'b1, OFS_OUTPUT_DATA, 8'hA5);
    rd_chk(OFS_OUTPUT_DATA, 32'h0000_00A5);
    // A write without the low byte lane must not land
    avs_byteenable <= 4'h2;
    bus(1'b1, OFS_OUTPUT_DATA, 8'h5A);
    avs_byteenable <= 4'h1;
    rd_chk(OFS_OUTPUT_DATA, 32'h0000_00A5);
    board <= 8'h3C;
    bus(1'b1, OFS_PIN_STATE, 8'hFF);
    settle();
    rd_chk(OFS_PIN_STATE, 32'h0000_003C);
    rd_chk(OFS_DIRECTION, READ_ZERO);
    bus(1'b1, 2'h3, 8'h77);
    rd_chk(2'h3, READ_ZERO);
    short_mask <= 8'h0F;
    bus(1'b1, OFS_DIRECTION, 8'h0F);
    settle();
    chk_reg(pin_oe, 32'h0000_000F);
    chk_reg(pin_out & pin_oe, 32'h0000_0005);
    rd_chk(OFS_PIN_STATE, 32'h0000_0035);
  endtask

  task automatic t_hold();
    board <= 8'hC3;
    for (int k = 0; k < 2; k++) begin
      manual_reset <= (k == 0);
      sw_standby <= (k == 1);
      bus(1'b1, OFS_OUTPUT_DATA, 8'h11);
      settle();
      rd_chk(OFS_OUTPUT_DATA, 32'h0000_00A5);
      rd_chk(OFS_PIN_STATE, 32'h0000_0035);
    end
    manual_reset <= 1'b0;
    sw_standby <= 1'b0;
  endtask

  task automatic t_hw();
    @(posedge clk);
    hw_standby <= 1'b1;
    short_mask <= 8'h00;
    board <= 8'h5A;
    settle();
    chk_reg(pin_oe, 32'h0000_0000);
    hw_standby <= 1'b0;
    settle();
    rd_chk(OFS_OUTPUT_DATA, RST_OUTPUT_DATA);
    rd_chk(OFS_PIN_STATE, 32'h0000_005A);
  endtask

  task automatic t_out(input logic [27:0] t, input logic [3:0] exp);
    tmr <= t;
    for (int v = 0; v < 2; v++) begin
      cmp <= v[0];
      settle();
      chk_reg(pin_oe[7:4], exp);
      chk_reg(pin_out[7:4] & exp, v[0] ? exp : 4'h0);
    end
  endtask

  task automatic t_in(input logic [27:0] t, input logic [13:0] p, input logic [7:0] exp);
    tmr <= t;
    psc <= p;
    board <= 8'hF0;
    settle();
    chk_reg(in_vec, exp);
    board <= 8'h00;
    settle();
    chk_reg(in_vec, 32'h0000_0000);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    {hw_standby, manual_reset, sw_standby, avs_read, avs_write, cmp} = 6'h00;
    avs_address = 2'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    tmr = 28'h000_0000;
    psc = 14'h0000;
    board = 8'h81;
    short_mask = 8'h00;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle();
    rd_chk(OFS_OUTPUT_DATA, RST_OUTPUT_DATA);
    rd_chk(OFS_PIN_STATE, 32'h0000_0081);
    chk_reg(pin_oe, RST_DIRECTION);
    t_regs();
    t_hold();
    t_hw();
    t_out(28'h011_0570, 4'hF);
    t_out(28'h436_5230, 4'hF);
    t_out(28'h004_0800, 4'h0);
    t_out(28'h221_2110, 4'h5);
    t_out(28'h311_3116, 4'h9);
    t_out(28'h311_3429, 4'h6);
    t_in(28'h088_0880, 14'h0000, 8'hF3);
    t_in(28'h488_58C0, 14'h0000, 8'hB3);
    t_in(28'h288_38C0, 14'h3800, 8'h07);
    t_in(28'h288_38C0, 14'h001C, 8'h07);
    t_in(28'h288_38C0, 14'h0700, 8'h03);
    t_in(28'h288_38C0, 14'h3000, 8'h0B);
    t_in(28'h288_38C0, 14'h0600, 8'h0B);
    t_in(28'h288_38C0, 14'h00A0, 8'h0B);
    t_in(28'h288_38C0, 14'h0014, 8'h0B);
    t_in(28'h288_38C0, 14'h2800, 8'h03);
    t_in(28'h288_38C0, 14'h0002, 8'h0F);
    t_in(28'h288_38C0, 14'h0001, 8'h0F);
    print_verdict();
  end
endmodule
